// ### rtl/eiop_port.sv
// eight-bit io port with direction, output latch, pin readback and pull-ups
//
// Notes on behaviour
// RULE1: direction register is write-only; reading it returns a fixed meaningless value.
// RULE2: direction cleared on power-on reset and hardware standby; kept otherwise.
// RULE3: extended modes with 8-bit bus: direction bit 1 drives pin, 0 inputs.
// RULE4: extended modes with 16-bit bus: pins belong to external data bus.
// RULE5: modes 3 and 7: pins are general io, direction per bit.
// RULE6: output latch is readable, writable and drives output pins.
// RULE7: output latch cleared on power-on reset and hardware standby; kept otherwise.
// RULE8: readback register is read-only; writes to it change nothing.
// RULE9: readback gives latch bit for outputs and live pin level for inputs.
// RULE10: readback follows pins after reset; frozen in manual reset, software standby.
// RULE11: pull-up enable register, cleared on reset and hardware standby, kept otherwise.
// RULE12: pull-up on only when direction bit 0 and enable bit 1.
// RULE13: pull-ups allowed in modes 3, 7 or 8-bit bus; off with 16-bit.
// RULE14: pull-ups off after reset and hardware standby; held in manual reset, standby.
// RULE15: register write stored at its edge; pins follow one cycle later.
`timescale 1ns/1ps
module eiop_port
  import eiop_pkg::*;
#(
  parameter int PORT_W = EIOP_PORT_W
)
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic MANUAL_RST,
  input wire logic SW_STANDBY,
  input wire logic HW_STANDBY,
  input wire logic [2:0] MODE,
  input wire logic BUS_16BIT,
  input wire logic [EIOP_ADDR_W-1:0] REG_ADDR,
  input wire logic [EIOP_REG_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [EIOP_REG_W-1:0] REG_RDATA,
  input wire logic [PORT_W-1:0] PIN_IN,
  output logic [PORT_W-1:0] PIN_OUT,
  output logic [PORT_W-1:0] PIN_OE,
  output logic [PORT_W-1:0] PIN_PULLUP,
  output logic DBUS_OWN
);

  if (PORT_W != EIOP_REG_W) begin : g_width_check
    $error("eiop_port: PORT_W must equal the register width");
  end

  typedef struct packed {
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] latch;
    logic [PORT_W-1:0] pullup_en;
    logic [PORT_W-1:0] readback;
    logic [EIOP_REG_W-1:0] rdata;
    logic [PORT_W-1:0] pin_out;
    logic [PORT_W-1:0] pin_oe;
    logic [PORT_W-1:0] pullup_on;
    logic dbus_own;
    logic [PORT_W-1:0] pin_meta;
    logic [PORT_W-1:0] pin_sync;
    logic hwsb_meta;
    logic hwsb_sync;
  } eiop_state_t;

  eiop_state_t s_reg;
  eiop_state_t s_next;

  logic single_chip;
  logic gpio_mode;
  logic frozen;
  logic hw_sb;
  logic sw_access;

  // port is general io unless an extended mode selects the 16-bit bus
  assign single_chip = (MODE == EIOP_MODE_SINGLE_A) || (MODE == EIOP_MODE_SINGLE_B);
  assign gpio_mode = single_chip || !BUS_16BIT;
  assign frozen = MANUAL_RST || SW_STANDBY;
  assign hw_sb = s_reg.hwsb_sync;
  assign sw_access = !hw_sb && !frozen;

  always_comb
  begin
    s_next = s_reg;

    // pin-side synchronisers
    s_next.pin_meta = PIN_IN;
    s_next.pin_sync = s_reg.pin_meta;
    s_next.hwsb_meta = HW_STANDBY;
    s_next.hwsb_sync = s_reg.hwsb_meta;

    if (hw_sb)
    begin
      s_next.dir = EIOP_DIR_RST; // [RULE2]
      s_next.latch = EIOP_LATCH_RST; // [RULE7]
      s_next.pullup_en = EIOP_PULLUP_RST; // [RULE11]
    end
    else if (sw_access && REG_WR)
    begin
      // stored on the write edge [RULE15]
      unique case (REG_ADDR)
        EIOP_ADDR_DIR: s_next.dir = REG_WDATA;
        EIOP_ADDR_LATCH: s_next.latch = REG_WDATA; // [RULE6]
        EIOP_ADDR_PULLUP: s_next.pullup_en = REG_WDATA; // [RULE11]
        default: s_next.dir = s_reg.dir; // readback and unmapped ignore writes [RULE8]
      endcase
    end

    // readback tracks pins except while frozen [RULE10]
    if (!frozen)
    begin
      s_next.readback = (s_reg.dir & s_reg.latch) | (~s_reg.dir & s_reg.pin_sync); // [RULE9]
    end

    // pin drive, ownership and pull-ups
    if (hw_sb)
    begin
      s_next.pin_oe = '0;
      s_next.pin_out = '0;
      s_next.pullup_on = '0; // [RULE14]
      s_next.dbus_own = !gpio_mode;
    end
    else if (!frozen)
    begin
      s_next.pin_out = s_reg.latch; // [RULE6]
      s_next.dbus_own = !gpio_mode; // [RULE4]
      if (gpio_mode)
      begin
        s_next.pin_oe = s_reg.dir; // [RULE3] [RULE5]
        s_next.pullup_on = ~s_reg.dir & s_reg.pullup_en; // [RULE12] [RULE13]
      end
      else
      begin
        s_next.pin_oe = '0; // [RULE4]
        s_next.pullup_on = '0; // [RULE13]
      end
    end

    // read data valid only in the cycle after the strobe
    s_next.rdata = EIOP_UNMAPPED_READ;
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        EIOP_ADDR_DIR: s_next.rdata = EIOP_DIR_READ_VALUE; // [RULE1]
        EIOP_ADDR_LATCH: s_next.rdata = s_reg.latch;
        EIOP_ADDR_READBACK: s_next.rdata = s_reg.readback; // [RULE9]
        EIOP_ADDR_PULLUP: s_next.rdata = s_reg.pullup_en;
        default: s_next.rdata = EIOP_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      s_reg <= '0; // [RULE2] [RULE7] [RULE11] [RULE14]
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign REG_RDATA = s_reg.rdata;
  assign PIN_OUT = s_reg.pin_out;
  assign PIN_OE = s_reg.pin_oe;
  assign PIN_PULLUP = s_reg.pullup_on;
  assign DBUS_OWN = s_reg.dbus_own;

  // checks

  property p_dir_read_fixed;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (REG_RD && REG_ADDR == EIOP_ADDR_DIR) |=> (REG_RDATA == EIOP_DIR_READ_VALUE);
  endproperty
  a_dir_read_fixed: assert property (p_dir_read_fixed) // [RULE1]
    else $error("direction register read did not return the fixed value");

  property p_hw_standby_clears;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    hw_sb |=> (s_reg.dir == EIOP_DIR_RST && s_reg.latch == EIOP_LATCH_RST
      && s_reg.pullup_en == EIOP_PULLUP_RST);
  endproperty
  a_hw_standby_clears: assert property (p_hw_standby_clears) // [RULE2]
    else $error("hardware standby did not clear the control registers");

  property p_frozen_keeps_regs;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (frozen && !hw_sb) |=> ($stable(s_reg.dir) && $stable(s_reg.latch)
      && $stable(s_reg.pullup_en));
  endproperty
  a_frozen_keeps_regs: assert property (p_frozen_keeps_regs) // [RULE7]
    else $error("registers changed during manual reset or software standby");

  property p_gpio_drive;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (sw_access && gpio_mode) |=> (PIN_OE == $past(s_reg.dir) && PIN_OUT == $past(s_reg.latch));
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) // [RULE3]
    else $error("pin drive does not follow direction and latch");

  property p_bus16_handover;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (sw_access && !single_chip && BUS_16BIT) |=> (PIN_OE == '0 && PIN_PULLUP == '0 && DBUS_OWN);
  endproperty
  a_bus16_handover: assert property (p_bus16_handover) // [RULE4]
    else $error("pins not handed to the data bus in 16-bit mode");

  property p_single_chip_gpio;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (sw_access && single_chip) |=> (!DBUS_OWN && PIN_OE == $past(s_reg.dir));
  endproperty
  a_single_chip_gpio: assert property (p_single_chip_gpio) // [RULE5]
    else $error("single-chip mode did not use pins as general io");

  property p_latch_write_read;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (sw_access && REG_WR && REG_ADDR == EIOP_ADDR_LATCH)
      ##1 (REG_RD && REG_ADDR == EIOP_ADDR_LATCH && !hw_sb)
      |=> (REG_RDATA == $past(REG_WDATA, 2));
  endproperty
  a_latch_write_read: assert property (p_latch_write_read) // [RULE6]
    else $error("output latch did not read back the written value");

  property p_readback_ignores_write;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (!hw_sb && REG_WR && REG_ADDR == EIOP_ADDR_READBACK)
      |=> ($stable(s_reg.dir) && $stable(s_reg.latch) && $stable(s_reg.pullup_en));
  endproperty
  a_readback_ignores_write: assert property (p_readback_ignores_write) // [RULE8]
    else $error("write to readback register changed state");

  property p_readback_value;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (!frozen) ##1 (REG_RD && REG_ADDR == EIOP_ADDR_READBACK)
      |=> (REG_RDATA == (($past(s_reg.dir, 2) & $past(s_reg.latch, 2))
        | (~$past(s_reg.dir, 2) & $past(s_reg.pin_sync, 2))));
  endproperty
  a_readback_value: assert property (p_readback_value) // [RULE9]
    else $error("readback value mixes latch and pin wrongly");

  property p_readback_frozen;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    frozen |=> $stable(s_reg.readback);
  endproperty
  a_readback_frozen: assert property (p_readback_frozen) // [RULE10]
    else $error("readback changed while frozen");

  property p_pullup_enable_rw;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (sw_access && REG_WR && REG_ADDR == EIOP_ADDR_PULLUP)
      ##1 (REG_RD && REG_ADDR == EIOP_ADDR_PULLUP && !hw_sb)
      |=> (REG_RDATA == $past(REG_WDATA, 2));
  endproperty
  a_pullup_enable_rw: assert property (p_pullup_enable_rw) // [RULE11]
    else $error("pull-up enable register did not read back");

  property p_pullup_state;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (sw_access && gpio_mode) |=> (PIN_PULLUP == (~$past(s_reg.dir) & $past(s_reg.pullup_en)));
  endproperty
  a_pullup_state: assert property (p_pullup_state) // [RULE12]
    else $error("pull-up state does not match direction and enable");

  property p_pullup_bus16_off;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (!single_chip && BUS_16BIT && !frozen) |=> (PIN_PULLUP == '0);
  endproperty
  a_pullup_bus16_off: assert property (p_pullup_bus16_off) // [RULE13]
    else $error("pull-up on with 16-bit bus");

  property p_pullup_hold;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (frozen && !hw_sb) |=> $stable(PIN_PULLUP);
  endproperty
  a_pullup_hold: assert property (p_pullup_hold) // [RULE14]
    else $error("pull-ups changed during manual reset or software standby");

  property p_write_to_pin;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (sw_access && gpio_mode && REG_WR && REG_ADDR == EIOP_ADDR_DIR)
      ##1 (sw_access && gpio_mode) |=> (PIN_OE == $past(REG_WDATA, 2));
  endproperty
  a_write_to_pin: assert property (p_write_to_pin) // [RULE15]
    else $error("direction write did not reach the pins one cycle later");

  property p_rdata_idle;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    !REG_RD |=> (REG_RDATA == EIOP_UNMAPPED_READ);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // [RULE15]
    else $error("read data not idle outside the cycle after a read");

  property p_unmapped_read;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (REG_RD && REG_ADDR != EIOP_ADDR_DIR && REG_ADDR != EIOP_ADDR_LATCH
      && REG_ADDR != EIOP_ADDR_READBACK && REG_ADDR != EIOP_ADDR_PULLUP)
      |=> (REG_RDATA == EIOP_UNMAPPED_READ);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) // [RULE15]
    else $error("unmapped read returned data");

  property p_dir_write_stored;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (sw_access && REG_WR && REG_ADDR == EIOP_ADDR_DIR)
      |=> (s_reg.dir == $past(REG_WDATA));
  endproperty
  a_dir_write_stored: assert property (p_dir_write_stored) // [RULE15]
    else $error("direction write not stored on its edge");

  property p_latch_write_stored;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (sw_access && REG_WR && REG_ADDR == EIOP_ADDR_LATCH)
      |=> (s_reg.latch == $past(REG_WDATA));
  endproperty
  a_latch_write_stored: assert property (p_latch_write_stored) // [RULE6]
    else $error("output latch write not stored on its edge");

  property p_pullup_write_stored;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (sw_access && REG_WR && REG_ADDR == EIOP_ADDR_PULLUP)
      |=> (s_reg.pullup_en == $past(REG_WDATA));
  endproperty
  a_pullup_write_stored: assert property (p_pullup_write_stored) // [RULE11]
    else $error("pull-up enable write not stored on its edge");

  property p_hw_standby_outputs;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    hw_sb |=> (PIN_OE == '0 && PIN_OUT == '0 && PIN_PULLUP == '0);
  endproperty
  a_hw_standby_outputs: assert property (p_hw_standby_outputs) // [RULE14]
    else $error("pins still driven or pulled up in hardware standby");

  property p_frozen_drive_hold;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (frozen && !hw_sb)
      |=> ($stable(PIN_OE) && $stable(PIN_OUT) && $stable(DBUS_OWN));
  endproperty
  a_frozen_drive_hold: assert property (p_frozen_drive_hold) // [RULE2]
    else $error("pin drive changed during manual reset or software standby");

  property p_readback_tracks;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (!frozen) |=> (s_reg.readback == (($past(s_reg.dir) & $past(s_reg.latch))
      | (~$past(s_reg.dir) & $past(s_reg.pin_sync))));
  endproperty
  a_readback_tracks: assert property (p_readback_tracks) // [RULE10]
    else $error("readback register does not follow pins and latch");

  property p_bus_ownership;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (!frozen) |=> (DBUS_OWN == !$past(gpio_mode));
  endproperty
  a_bus_ownership: assert property (p_bus_ownership) // [RULE4]
    else $error("data bus ownership does not follow mode and bus width");

endmodule // eiop_port

// ### rtl/eiop_pkg.sv
// shared constants for the eight-bit io port with pull-ups
package eiop_pkg;

  // port and register widths
  localparam int EIOP_PORT_W = 8;
  localparam int EIOP_REG_W = 8;
  localparam int EIOP_ADDR_W = 16;

  // byte addresses, lower 16 bits
  localparam logic [15:0] EIOP_ADDR_DIR = 16'hfebd;
  localparam logic [15:0] EIOP_ADDR_READBACK = 16'hff5d;
  localparam logic [15:0] EIOP_ADDR_LATCH = 16'hff6d;
  localparam logic [15:0] EIOP_ADDR_PULLUP = 16'hff74;

  // values after power-on reset and in hardware standby
  localparam logic [7:0] EIOP_DIR_RST = 8'h00;
  localparam logic [7:0] EIOP_LATCH_RST = 8'h00;
  localparam logic [7:0] EIOP_PULLUP_RST = 8'h00;

  // answer to a read of the write-only direction register
  localparam logic [7:0] EIOP_DIR_READ_VALUE = 8'hff;
  // answer to an unmapped address
  localparam logic [7:0] EIOP_UNMAPPED_READ = 8'h00;

  // operating modes in which the port is always general io
  localparam logic [2:0] EIOP_MODE_SINGLE_A = 3'h3;
  localparam logic [2:0] EIOP_MODE_SINGLE_B = 3'h7;

  // synchroniser depth for pin-side inputs
  localparam int EIOP_SYNC_STAGES = 2;

endpackage : eiop_pkg

// ### tb/eiop_pins_model.sv
// pin-side model: resolves each pad from port drive, pull-up and outside driver
`timescale 1ns/1ps
module eiop_pins_model
  import eiop_pkg::*;
(
  input wire logic clk,
  input wire logic [EIOP_PORT_W-1:0] oe,
  input wire logic [EIOP_PORT_W-1:0] drv,
  input wire logic [EIOP_PORT_W-1:0] pu,
  input wire logic [EIOP_PORT_W-1:0] ext,
  input wire logic [EIOP_PORT_W-1:0] ext_en,
  output logic [EIOP_PORT_W-1:0] level
);
  logic [EIOP_PORT_W-1:0] float_reg = '0;
  // undriven pads without pull-up wander each cycle
  always_ff @(posedge clk)
    float_reg <= ~float_reg;
  always_comb
    level = (oe & drv) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pu | float_reg));
endmodule // eiop_pins_model

// ### tb/eiop_port_tb_top.sv
// self-checking bench for the eight-bit io port
`timescale 1ns/1ps
module eiop_port_tb_top;
  import eiop_pkg::*;
  logic CLK_SYS = 1'b0;
  logic SYS_RST, MANUAL_RST, SW_STANDBY, HW_STANDBY, BUS_16BIT, REG_WR, REG_RD, DBUS_OWN;
  logic [2:0] MODE;
  logic [15:0] REG_ADDR;
  logic [7:0] REG_WDATA, REG_RDATA, PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP, ext, ext_en;
  logic [7:0] dir, lat, pu, d, m, e;
  logic [31:0] seed = 32'h5686_e19c;
  int miscompares = 0;
  int compares = 0;
  always #5 CLK_SYS = ~CLK_SYS;
  eiop_port i_eiop_port (.CLK_SYS, .SYS_RST, .MANUAL_RST, .SW_STANDBY, .HW_STANDBY, .MODE,
    .BUS_16BIT, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .PIN_IN, .PIN_OUT,
    .PIN_OE, .PIN_PULLUP, .DBUS_OWN);
  eiop_pins_model i_eiop_pins_model (.clk(CLK_SYS), .oe(PIN_OE), .drv(PIN_OUT),
    .pu(PIN_PULLUP), .ext(ext), .ext_en(ext_en), .level(PIN_IN));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic gpio();
    return MODE == EIOP_MODE_SINGLE_A || MODE == EIOP_MODE_SINGLE_B || !BUS_16BIT;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d, miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge CLK_SYS);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= v;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge CLK_SYS);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  // write then read the same address with no gap between the strobes
  task automatic wr_rd(input logic [15:0] a, input logic [7:0] v);
    @(posedge CLK_SYS);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= v;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
    REG_RD <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  task automatic settle();
    repeat (8) @(posedge CLK_SYS);
    #1;
  endtask
  initial
  begin
    {MANUAL_RST, SW_STANDBY, HW_STANDBY, BUS_16BIT, REG_WR, REG_RD} = '0;
    SYS_RST = 1'b1;
    MODE = EIOP_MODE_SINGLE_A;
    REG_ADDR = '0;
    REG_WDATA = '0;
    ext = 8'ha5;
    ext_en = 8'hff;
    repeat (8) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    settle();
    chk(PIN_OE, EIOP_DIR_RST);
    rd(EIOP_ADDR_READBACK);
    chk(d, 8'ha5);
    rd(EIOP_ADDR_DIR);
    chk(d, EIOP_DIR_READ_VALUE);
    rd(16'h0000);
    chk(d, EIOP_UNMAPPED_READ);
    wr(EIOP_ADDR_DIR, 8'h5a);
    #1 chk(PIN_OE, 8'h00);
    @(posedge CLK_SYS);
    #1 chk(PIN_OE, 8'h5a);
    for (int i = 0; i < 24; i++)
    begin
      seed = lfsr(seed);
      dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
      lat = seed[15:8];
      pu = (i == 0) ? 8'hff : seed[23:16];
      @(posedge CLK_SYS);
      MODE <= seed[26:24];
      BUS_16BIT <= seed[27];
      seed = lfsr(seed);
      ext <= seed[7:0];
      ext_en <= seed[15:8];
      wr(EIOP_ADDR_DIR, dir);
      wr_rd(EIOP_ADDR_LATCH, lat);
      chk(d, lat);
      wr_rd(EIOP_ADDR_PULLUP, pu);
      chk(d, pu);
      wr(EIOP_ADDR_READBACK, ~lat);
      settle();
      chk({7'h00, DBUS_OWN}, {7'h00, !gpio()});
      chk(PIN_PULLUP, gpio() ? ~dir & pu : 8'h00);
      rd(EIOP_ADDR_LATCH);
      chk(d, lat);
      rd(EIOP_ADDR_PULLUP);
      chk(d, pu);
      if (gpio())
      begin
        chk(PIN_OE, dir);
        chk(PIN_OUT & dir, lat & dir);
        rd(EIOP_ADDR_READBACK);
        m = dir | ext_en | pu;
        e = (dir & lat) | (~dir & ((ext_en & ext) | (~ext_en & pu)));
        chk(d & m, e & m);
      end
      else
        chk(PIN_OE, 8'h00);
    end
    @(posedge CLK_SYS);
    MODE <= EIOP_MODE_SINGLE_B;
    ext_en <= 8'hff;
    wr(EIOP_ADDR_DIR, 8'h0f);
    wr(EIOP_ADDR_LATCH, 8'h3c);
    wr(EIOP_ADDR_PULLUP, 8'hf0);
    // manual reset, then software standby: nothing stored may move
    for (int k = 0; k < 2; k++)
    begin
      @(posedge CLK_SYS);
      ext <= 8'h00;
      settle();
      @(posedge CLK_SYS);
      {SW_STANDBY, MANUAL_RST} <= 2'b01 << k;
      wr(EIOP_ADDR_LATCH, 8'hc3);
      wr(EIOP_ADDR_DIR, 8'hf0);
      ext <= 8'hff;
      settle();
      chk(PIN_OE, 8'h0f);
      chk(PIN_PULLUP, 8'hf0);
      rd(EIOP_ADDR_READBACK);
      chk(d, 8'h0c);
      @(posedge CLK_SYS);
      {SW_STANDBY, MANUAL_RST} <= 2'b00;
      rd(EIOP_ADDR_LATCH);
      chk(d, 8'h3c);
    end
    @(posedge CLK_SYS);
    HW_STANDBY <= 1'b1;
    settle();
    chk(PIN_OE, 8'h00);
    chk(PIN_PULLUP, 8'h00);
    @(posedge CLK_SYS);
    HW_STANDBY <= 1'b0;
    settle();
    rd(EIOP_ADDR_LATCH);
    chk(d, EIOP_LATCH_RST);
    rd(EIOP_ADDR_PULLUP);
    chk(d, EIOP_PULLUP_RST);
    rd(EIOP_ADDR_READBACK);
    chk(d, 8'hff);
    wr(EIOP_ADDR_PULLUP, 8'h81);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    rd(EIOP_ADDR_PULLUP);
    chk(d, EIOP_PULLUP_RST);
    tally_and_finish();
  end
  initial
  begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
endmodule // eiop_port_tb_top
